// File: logic/rcw_rtc_aux.sv
`timescale 1ns/1ns
module rcw_rtc_aux
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Register port
    input wire rcw_pkg::rcw_req_t req,
    output logic [7:0] rdata_q,
    // Current time from the clock counters
    input wire rcw_pkg::rcw_time_t now,
    // Oscillator
    input wire logic osc_level,
    // Power and oscillator monitors
    input wire logic vcc_low,
    input wire logic backup_low_level,
    input wire logic osc_failed,
    // Clock counter side
    output logic sec_tick,
    output logic store_start_q,
    output logic on_backup,
    // Interrupt pin
    output logic int_out_q,
    output logic int_oe_n_q
);
    logic [7:0] flags_q;
    logic [7:0] alm_stage_q [4];
    logic [7:0] alm_live_q [4];
    logic [7:0] irq_ctl_q;
    logic [5:0] dog_tmo_q;
    logic dog_lock_q;
    logic [5:0] dog_cnt_q;
    logic [7:0] trim_q;
    rcw_pkg::rcw_pwr_t pwr_q;
    logic vcc_low_q;
    logic backup_seen_q;
    logic osc_q;
    logic osc_tick;
    logic sec_wave;
    logic tick_32hz;
    logic [14:0] free_q;
    logic sec_tick_q;
    logic wr_ok;
    logic rd_ok;
    logic flags_wr;
    logic flags_rd;
    logic gate_fall;
    logic dog_kick;
    logic dog_hit;
    logic alarm_hit;
    logic [3:0] field_eq;
    logic [7:0] now_f [4];
    logic wave;
    logic irq_act;
    logic osc_run;

    // Host access is shut off on backup
    assign on_backup = (pwr_q == rcw_pkg::PWR_BACKUP);
    assign wr_ok = req.wr && !on_backup;
    assign rd_ok = req.rd && !on_backup;
    assign flags_wr = wr_ok && (req.addr == rcw_pkg::OFF_FLAGS);
    assign flags_rd = rd_ok && (req.addr == rcw_pkg::OFF_FLAGS);
    assign gate_fall = flags_wr && flags_q[rcw_pkg::FLG_WR_GATE]
        && !req.wdata[rcw_pkg::FLG_WR_GATE];

    // Oscillator edge detect
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            osc_q <= 1'b0;
        else
            osc_q <= osc_level;
    end
    assign osc_tick = osc_level && !osc_q;
    assign osc_run = !trim_q[rcw_pkg::TRIM_OSC_OFF];

    rcw_osc_div u_div
    (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .osc_tick(osc_tick),
        .osc_run(osc_run),
        .cal_mag(trim_q[rcw_pkg::TRIM_MAG_W-1:0]),
        .cal_pos(trim_q[rcw_pkg::TRIM_SIGN]),
        .sec_tick(sec_tick),
        .sec_wave(sec_wave),
        .tick_32hz(tick_32hz),
        .free_q(free_q)
    );

    // Power state: switchover and store request
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pwr_q <= rcw_pkg::PWR_MAIN;
            vcc_low_q <= 1'b0;
            store_start_q <= 1'b0;
        end
        else
        begin
            vcc_low_q <= vcc_low;
            store_start_q <= vcc_low && !vcc_low_q;
            case (pwr_q)
                rcw_pkg::PWR_MAIN:
                    if (vcc_low)
                        pwr_q <= rcw_pkg::PWR_BACKUP;
                rcw_pkg::PWR_BACKUP:
                    if (!vcc_low)
                        pwr_q <= rcw_pkg::PWR_MAIN;
                default:
                    pwr_q <= rcw_pkg::PWR_MAIN;
            endcase
        end
    end

    // Backup supply watch, held until main power returns
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            backup_seen_q <= 1'b0;
        else if (backup_low_level)
            backup_seen_q <= 1'b1;
        else if (!on_backup)
            backup_seen_q <= 1'b0;
    end

    // Alarm registers: staged writes, applied on gate fall
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_alm
            always_ff @(posedge sys_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    alm_stage_q[gi] <= rcw_pkg::RST_ALARM;
                    alm_live_q[gi] <= rcw_pkg::RST_ALARM;
                end
                else
                begin
                    if (wr_ok && (req.addr ==
                        rcw_pkg::OFF_ALM_SEC + 4'(gi)))
                        alm_stage_q[gi] <= req.wdata;
                    if (gate_fall)
                        alm_live_q[gi] <= alm_stage_q[gi];
                end
            end
            // Masked field counts as matched
            assign field_eq[gi] = alm_live_q[gi][rcw_pkg::ALM_MASK] ||
                (alm_live_q[gi][6:0] == now_f[gi][6:0]);
        end
    endgenerate
    assign now_f[0] = now.sec;
    assign now_f[1] = now.min;
    assign now_f[2] = now.hour;
    assign now_f[3] = now.date;

    // Compare once per second, after the counters have advanced
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            sec_tick_q <= 1'b0;
        else
            sec_tick_q <= sec_tick;
    end
    // All masks set disables the alarm
    assign alarm_hit = sec_tick_q && (&field_eq) && !(&{
        alm_live_q[0][rcw_pkg::ALM_MASK],
        alm_live_q[1][rcw_pkg::ALM_MASK],
        alm_live_q[2][rcw_pkg::ALM_MASK],
        alm_live_q[3][rcw_pkg::ALM_MASK]});

    // Interrupt control register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_ctl_q <= rcw_pkg::RST_IRQ_CTL;
        else if (wr_ok && (req.addr == rcw_pkg::OFF_IRQ_CTL))
            irq_ctl_q <= req.wdata;
    end

    // Trim register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            trim_q <= rcw_pkg::RST_TRIM;
        else if (wr_ok && (req.addr == rcw_pkg::OFF_TRIM))
            trim_q <= req.wdata;
    end

    // Watchdog register: timeout writes honour the lock
    assign dog_kick = wr_ok && (req.addr == rcw_pkg::OFF_DOG) &&
        req.wdata[rcw_pkg::DOG_KICK];
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dog_tmo_q <= rcw_pkg::RST_DOG_TMO;
            dog_lock_q <= 1'b0;
        end
        else if (wr_ok && (req.addr == rcw_pkg::OFF_DOG))
        begin
            dog_lock_q <= req.wdata[rcw_pkg::DOG_LOCK];
            if (!req.wdata[rcw_pkg::DOG_LOCK])
                dog_tmo_q <= req.wdata[rcw_pkg::DOG_TMO_W-1:0];
        end
    end

    // Watchdog down counter
    // A kick in the same cycle as the last tick wins over expiry
    assign dog_hit = tick_32hz && !dog_kick && (dog_tmo_q != 6'h00) &&
        (dog_cnt_q == 6'h01);
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            dog_cnt_q <= rcw_pkg::RST_DOG_TMO;
        else if (dog_kick)
            dog_cnt_q <= req.wdata[rcw_pkg::DOG_LOCK] ?
                dog_tmo_q : req.wdata[rcw_pkg::DOG_TMO_W-1:0];
        else if (dog_tmo_q == 6'h00)
            dog_cnt_q <= 6'h00;
        else if (tick_32hz && (dog_cnt_q != 6'h00))
            dog_cnt_q <= dog_cnt_q - 6'h01;
    end

    // Flags: hardware set wins over read clear
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            flags_q <= 8'h00;
        else
        begin
            if (flags_rd)
            begin
                flags_q[rcw_pkg::FLG_DOG] <= 1'b0;
                flags_q[rcw_pkg::FLG_ALARM] <= 1'b0;
                flags_q[rcw_pkg::FLG_POWER_FAIL] <= 1'b0;
                flags_q[rcw_pkg::FLG_OSC_FAIL] <= 1'b0;
                flags_q[rcw_pkg::FLG_BACKUP_FAIL] <= 1'b0;
            end
            if (flags_wr)
            begin
                flags_q[rcw_pkg::FLG_WR_GATE] <=
                    req.wdata[rcw_pkg::FLG_WR_GATE];
                if (flags_q[rcw_pkg::FLG_WR_GATE])
                begin
                    flags_q[rcw_pkg::FLG_CAL_TEST] <=
                        req.wdata[rcw_pkg::FLG_CAL_TEST];
                    flags_q[rcw_pkg::FLG_RD_HOLD] <=
                        req.wdata[rcw_pkg::FLG_RD_HOLD];
                end
            end
            if (dog_hit)
                flags_q[rcw_pkg::FLG_DOG] <= 1'b1;
            if (alarm_hit)
                flags_q[rcw_pkg::FLG_ALARM] <= 1'b1;
            if (store_start_q)
                flags_q[rcw_pkg::FLG_POWER_FAIL] <= 1'b1;
            if (osc_failed)
                flags_q[rcw_pkg::FLG_OSC_FAIL] <= 1'b1;
            if (on_backup && !vcc_low && backup_seen_q)
                flags_q[rcw_pkg::FLG_BACKUP_FAIL] <= 1'b1;
        end
    end

    // Read data
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_q <= 8'h00;
        else if (rd_ok)
        begin
            case (req.addr)
                rcw_pkg::OFF_FLAGS:
                    rdata_q <= flags_q;
                rcw_pkg::OFF_ALM_SEC:
                    rdata_q <= alm_stage_q[0];
                rcw_pkg::OFF_ALM_MIN:
                    rdata_q <= alm_stage_q[1];
                rcw_pkg::OFF_ALM_HOUR:
                    rdata_q <= alm_stage_q[2];
                rcw_pkg::OFF_ALM_DATE:
                    rdata_q <= alm_stage_q[3];
                rcw_pkg::OFF_IRQ_CTL:
                    rdata_q <= irq_ctl_q;
                rcw_pkg::OFF_DOG:
                    rdata_q <= {1'b0, dog_lock_q, dog_tmo_q};
                rcw_pkg::OFF_TRIM:
                    rdata_q <= trim_q;
                default:
                    rdata_q <= 8'h00;
            endcase
        end
    end

    // Square wave rate select
    always_comb
    begin
        case (rcw_pkg::rcw_wave_t'({irq_ctl_q[rcw_pkg::IRQ_WAVE_HI],
            irq_ctl_q[rcw_pkg::IRQ_WAVE_LO]}))
            rcw_pkg::WAVE_1HZ:
                wave = sec_wave;
            rcw_pkg::WAVE_512HZ:
                wave = free_q[rcw_pkg::TAP_512];
            rcw_pkg::WAVE_4096HZ:
                wave = free_q[rcw_pkg::TAP_4096];
            rcw_pkg::WAVE_32KHZ:
                wave = osc_q;
            default:
                wave = 1'b0;
        endcase
    end

    // Enabled sources, only on main power
    assign irq_act = !on_backup && (
        (flags_q[rcw_pkg::FLG_DOG] && irq_ctl_q[rcw_pkg::IRQ_DOG_EN]) ||
        (flags_q[rcw_pkg::FLG_ALARM] &&
            irq_ctl_q[rcw_pkg::IRQ_ALARM_EN]) ||
        (flags_q[rcw_pkg::FLG_POWER_FAIL] &&
            irq_ctl_q[rcw_pkg::IRQ_PF_EN]));

    // Interrupt pin driver
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            int_out_q <= 1'b0;
            int_oe_n_q <= 1'b1;
        end
        else if (flags_q[rcw_pkg::FLG_CAL_TEST])
        begin
            int_out_q <= free_q[rcw_pkg::TAP_512];
            int_oe_n_q <= 1'b0;
        end
        else if (irq_ctl_q[rcw_pkg::IRQ_WAVE_ON] && !on_backup)
        begin
            int_out_q <= wave;
            int_oe_n_q <= 1'b0;
        end
        else if (irq_act)
        begin
            int_out_q <= 1'b1;
            int_oe_n_q <= 1'b0;
        end
        else
        begin
            int_out_q <= 1'b0;
            int_oe_n_q <= 1'b1;
        end
    end
endmodule : rcw_rtc_aux

// File: inc/rcw_pkg.sv
package rcw_pkg;
    // Register offsets
    localparam logic [3:0] OFF_FLAGS = 4'h0;
    localparam logic [3:0] OFF_ALM_SEC = 4'h2;
    localparam logic [3:0] OFF_ALM_MIN = 4'h3;
    localparam logic [3:0] OFF_ALM_HOUR = 4'h4;
    localparam logic [3:0] OFF_ALM_DATE = 4'h5;
    localparam logic [3:0] OFF_IRQ_CTL = 4'h6;
    localparam logic [3:0] OFF_DOG = 4'h7;
    localparam logic [3:0] OFF_TRIM = 4'h8;
    // Flag register bits
    localparam int FLG_RD_HOLD = 0;
    localparam int FLG_WR_GATE = 1;
    localparam int FLG_CAL_TEST = 2;
    localparam int FLG_BACKUP_FAIL = 3;
    localparam int FLG_OSC_FAIL = 4;
    localparam int FLG_POWER_FAIL = 5;
    localparam int FLG_ALARM = 6;
    localparam int FLG_DOG = 7;
    // Alarm field match-exclude bit
    localparam int ALM_MASK = 7;
    // Interrupt control bits
    localparam int IRQ_WAVE_LO = 0;
    localparam int IRQ_WAVE_HI = 1;
    localparam int IRQ_WAVE_ON = 4;
    localparam int IRQ_PF_EN = 5;
    localparam int IRQ_ALARM_EN = 6;
    localparam int IRQ_DOG_EN = 7;
    // Watchdog register bits
    localparam int DOG_KICK = 7;
    localparam int DOG_LOCK = 6;
    localparam int DOG_TMO_W = 6;
    // Trim register bits
    localparam int TRIM_SIGN = 5;
    localparam int TRIM_MAG_W = 5;
    localparam int TRIM_OSC_OFF = 7;
    // Reset values
    localparam logic [7:0] RST_ALARM = 8'h80;
    localparam logic [7:0] RST_IRQ_CTL = 8'h00;
    localparam logic [5:0] RST_DOG_TMO = 6'h00;
    localparam logic [7:0] RST_TRIM = 8'h00;
    // Oscillator divider counts in oscillator cycles, then the second and minute wrap limits
    localparam logic [16:0] SEC_NOM_CYC = 17'h0_8000;
    localparam logic [16:0] SEC_HALF_CYC = 17'h0_4000;
    localparam logic [16:0] CAL_NEG_CYC = 17'h0_0080;
    localparam logic [16:0] CAL_POS_CYC = 17'h0_0100;
    localparam logic [5:0] SEC_LAST = 6'h3B;
    localparam logic [5:0] CAL_MIN_LAST = 6'h3F;
    localparam logic [9:0] DOG_DIV_LAST = 10'h3FF;
    // Free prescaler taps for square waves
    localparam int TAP_512 = 5;
    localparam int TAP_4096 = 2;

    typedef enum logic [0:0]
    {
        PWR_MAIN = 1'b0,
        PWR_BACKUP = 1'b1
    } rcw_pwr_t;

    typedef enum logic [1:0]
    {
        WAVE_1HZ = 2'b00,
        WAVE_512HZ = 2'b01,
        WAVE_4096HZ = 2'b10,
        WAVE_32KHZ = 2'b11
    } rcw_wave_t;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } rcw_req_t;

    typedef struct packed
    {
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } rcw_time_t;
endpackage : rcw_pkg

// File: logic/rcw_osc_div.sv
`timescale 1ns/1ns
module rcw_osc_div
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Oscillator and trim
    input wire logic osc_tick,
    input wire logic osc_run,
    input wire logic [4:0] cal_mag,
    input wire logic cal_pos,
    // Ticks and taps
    output logic sec_tick,
    output logic sec_wave,
    output logic tick_32hz,
    output logic [14:0] free_q
);
    logic [16:0] cnt_q;
    logic [5:0] sec_q;
    logic [5:0] min_q;
    logic adj;
    logic [16:0] limit;
    logic step;

    assign step = osc_tick & osc_run;
    // Adjust second zero of each of the first 2N minutes
    assign adj = (sec_q == 6'h00) && (min_q < {cal_mag, 1'b0});
    always_comb
    begin
        limit = rcw_pkg::SEC_NOM_CYC;
        if (adj && cal_pos)
            limit = rcw_pkg::SEC_NOM_CYC + rcw_pkg::CAL_POS_CYC;
        else if (adj)
            limit = rcw_pkg::SEC_NOM_CYC - rcw_pkg::CAL_NEG_CYC;
    end
    assign sec_tick = step && (cnt_q == limit - 17'h0_0001);
    assign sec_wave = cnt_q < rcw_pkg::SEC_HALF_CYC;
    // Untrimmed prescaler feeds the watchdog and test output
    assign tick_32hz = step && (free_q[9:0] == rcw_pkg::DOG_DIV_LAST);

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            free_q <= 15'h0000;
        else if (step)
            free_q <= free_q + 15'h0001;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= 17'h0_0000;
            sec_q <= 6'h00;
            min_q <= 6'h00;
        end
        else if (sec_tick)
        begin
            cnt_q <= 17'h0_0000;
            sec_q <= (sec_q == rcw_pkg::SEC_LAST) ? 6'h00 : sec_q + 6'h01;
            if (sec_q == rcw_pkg::SEC_LAST) // 64-minute cycle
                min_q <= (min_q == rcw_pkg::CAL_MIN_LAST) ?
                    6'h00 : min_q + 6'h01;
        end
        else if (step)
            cnt_q <= cnt_q + 17'h0_0001;
    end
endmodule : rcw_osc_div

// File: bench/rcw_rtc_aux_sva.sv
`timescale 1ns/1ns
module rcw_rtc_aux_sva
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Watched ports
    input wire rcw_pkg::rcw_req_t req,
    input wire logic [7:0] rdata_q,
    input wire logic vcc_low,
    input wire logic sec_tick,
    input wire logic store_start_q,
    input wire logic on_backup,
    input wire logic int_out_q,
    input wire logic int_oe_n_q
);
    logic rd_ok;
    logic wr_ok;
    logic [7:0] trim_w_q;
    logic [5:0] tmo_w_q;

    assign rd_ok = req.rd && !on_backup;
    assign wr_ok = req.wr && !on_backup;

    // Shadow of the last accepted trim write
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            trim_w_q <= rcw_pkg::RST_TRIM;
        else if (wr_ok && req.addr == rcw_pkg::OFF_TRIM)
            trim_w_q <= req.wdata;
    end

    // Shadow of the timeout field, kept only for unlocked writes
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            tmo_w_q <= rcw_pkg::RST_DOG_TMO;
        else if (wr_ok && req.addr == rcw_pkg::OFF_DOG
                 && !req.wdata[rcw_pkg::DOG_LOCK])
            tmo_w_q <= req.wdata[5:0];
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_store_after_drop: assert property (
        $rose(vcc_low) && !on_backup |=> store_start_q && on_backup)
        else $error("no store pulse after supply drop");
    a_store_cause: assert property (
        store_start_q |-> $past(vcc_low) && !$past(on_backup)
        && !$past(store_start_q))
        else $error("store pulse without supply drop");
    a_backup_follows: assert property (vcc_low |=> on_backup)
        else $error("backup not entered");
    a_main_return: assert property (!vcc_low |=> !on_backup)
        else $error("backup not left");
    a_backup_read_hold: assert property (
        on_backup ##1 on_backup |-> $stable(rdata_q))
        else $error("read data changed on backup");
    a_kick_reads_zero: assert property (
        rd_ok && req.addr == rcw_pkg::OFF_DOG |=> !rdata_q[7])
        else $error("kick bit reads one");
    a_dog_lock_keep: assert property (
        rd_ok && req.addr == rcw_pkg::OFF_DOG |=> rdata_q[5:0] == tmo_w_q)
        else $error("timeout field wrong");
    a_trim_readback: assert property (
        rd_ok && req.addr == rcw_pkg::OFF_TRIM |=> rdata_q == trim_w_q)
        else $error("trim readback wrong");
    a_sec_tick_pulse: assert property (sec_tick |=> !sec_tick [*8])
        else $error("second tick too close");

    c_store: cover property (store_start_q);
    c_int_high: cover property (!int_oe_n_q && int_out_q);
    c_locked_write: cover property (
        wr_ok && req.addr == rcw_pkg::OFF_DOG && req.wdata[6]);
endmodule : rcw_rtc_aux_sva

bind rcw_rtc_aux rcw_rtc_aux_sva i_sva
(
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .req(req),
    .rdata_q(rdata_q),
    .vcc_low(vcc_low),
    .sec_tick(sec_tick),
    .store_start_q(store_start_q),
    .on_backup(on_backup),
    .int_out_q(int_out_q),
    .int_oe_n_q(int_oe_n_q)
);

// File: bench/rcw_host_mdl.sv
`timescale 1ns/1ns
module rcw_host_mdl
(
    // Clock
    input wire logic sys_clk,
    // Register port
    input wire logic [7:0] rdata_q,
    output rcw_pkg::rcw_req_t req
);
    initial req = '0;

    // One access, then the strobe is dropped a cycle later
    task acc(input logic w, input logic [3:0] a, input logic [7:0] d,
             output logic [7:0] q);
        repeat ($urandom_range(0, 2)) @(negedge sys_clk);
        @(negedge sys_clk);
        req = '{w, !w, a, d};
        @(negedge sys_clk);
        req = '0;
        q = rdata_q;
    endtask : acc

    task wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask : wr

    // Gate opened, one write, gate closed with final flag value
    task gate_wr(input logic [3:0] a, input logic [7:0] d,
                 input logic [7:0] fin);
        wr(rcw_pkg::OFF_FLAGS, 8'h02);
        wr(a, d);
        wr(rcw_pkg::OFF_FLAGS, fin);
    endtask : gate_wr

    task set_alarm(input rcw_pkg::rcw_time_t t);
        wr(rcw_pkg::OFF_FLAGS, 8'h02);
        wr(rcw_pkg::OFF_ALM_SEC, {1'b0, t.sec[6:0]});
        wr(rcw_pkg::OFF_ALM_MIN, {1'b0, t.min[6:0]});
        wr(rcw_pkg::OFF_ALM_HOUR, 8'h80);
        wr(rcw_pkg::OFF_ALM_DATE, 8'h80);
        wr(rcw_pkg::OFF_FLAGS, 8'h00);
    endtask : set_alarm
endmodule : rcw_host_mdl

// File: bench/rcw_rtc_aux_tb_top.sv
`timescale 1ns/1ns
module rcw_rtc_aux_tb_top;
    logic sys_clk;
    logic arst_n;
    logic osc_level;
    logic vcc_low;
    logic backup_low_level;
    logic osc_failed;
    logic sec_tick;
    logic store_start_q;
    logic on_backup;
    logic int_out_q;
    logic int_oe_n_q;
    logic [7:0] rdata_q;
    logic [7:0] q;
    logic [7:0] v;
    rcw_pkg::rcw_req_t req;
    rcw_pkg::rcw_time_t now;
    int num_errors;
    int tests_run;
    int t;

    rcw_host_mdl i_host (.sys_clk(sys_clk), .rdata_q(rdata_q), .req(req));

    rcw_rtc_aux i_dut
    (
        .sys_clk(sys_clk), .arst_n(arst_n), .req(req), .rdata_q(rdata_q),
        .now(now), .osc_level(osc_level), .vcc_low(vcc_low),
        .backup_low_level(backup_low_level), .osc_failed(osc_failed),
        .sec_tick(sec_tick), .store_start_q(store_start_q),
        .on_backup(on_backup), .int_out_q(int_out_q),
        .int_oe_n_q(int_oe_n_q)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Oscillator sped up to half the system rate to keep the run short
    initial osc_level = 1'b0;
    always @(negedge sys_clk) osc_level <= ~osc_level;

    task wrap_up;
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task rd(input logic [3:0] a);
        i_host.acc(1'b0, a, 8'h00, q);
    endtask : rd

    // Counts pin transitions over n cycles
    task count_tg(input int n);
        logic last;
        last = int_out_q;
        t = 0;
        repeat (n)
        begin
            @(negedge sys_clk);
            if (int_out_q !== last)
                t++;
            last = int_out_q;
        end
    endtask : count_tg

    function automatic int exp_tg(input logic [1:0] code, input int n);
        int sh;
        sh = (code == 2'b00) ? 15 : (code == 2'b01) ? 6
           : (code == 2'b10) ? 3 : 0;
        return n * 2 / (2 << sh);
    endfunction : exp_tg

    task chk_tg(input int e, input string m);
        tests_run++;
        if (t < e - 2 || t > e + 2 || int_oe_n_q !== 1'b0)
        begin
            num_errors++;
            $display("MISMATCH %0t: %s toggles %0d exp %0d", $time, m, t, e);
        end
    endtask : chk_tg

    task wait_cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_cyc

    // Limit reckoned from the alarm second plus the watchdog waits
    initial
    begin
        #1_000_000;
        num_errors++;
        wrap_up();
    end

    initial
    begin
        num_errors = 0;
        tests_run = 0;
        arst_n = 1'b0;
        vcc_low = 1'b0;
        backup_low_level = 1'b0;
        osc_failed = 1'b0;
        v = 8'($urandom(32'h442c));
        now = '{8'h15, 8'h09,
                {4'($urandom_range(0, 5)), 4'($urandom_range(0, 9))},
                {4'($urandom_range(0, 5)), 4'($urandom_range(0, 9))}};
        wait_cyc(6);
        arst_n = 1'b1;
        rd(rcw_pkg::OFF_TRIM); chk(q, rcw_pkg::RST_TRIM, "trim rst");
        rd(rcw_pkg::OFF_ALM_DATE); chk(q, rcw_pkg::RST_ALARM, "alm rst");
        rd(rcw_pkg::OFF_DOG); chk(q, 8'h00, "dog rst");
        rd(rcw_pkg::OFF_FLAGS); chk(q, 8'h00, "flag rst");
        // Seconds and minutes matched, hour and date excluded
        i_host.set_alarm(now);
        i_host.wr(rcw_pkg::OFF_IRQ_CTL, 8'h40);
        t = 0;
        // The second pulse ends at the edge, so look just before it
        while (sec_tick !== 1'b1 && t < 70000)
        begin
            @(posedge sys_clk);
            t++;
        end
        wait_cyc(4);
        chk({6'h0, int_oe_n_q, int_out_q}, 8'h01, "alarm pin");
        rd(rcw_pkg::OFF_FLAGS); chk(q & 8'hC0, 8'h40, "alarm flag");
        wait_cyc(1);
        chk({7'h0, int_oe_n_q}, 8'h01, "alarm pin clear");
        rd(rcw_pkg::OFF_FLAGS); chk(q & 8'h40, 8'h00, "flag cleared");
        i_host.wr(rcw_pkg::OFF_IRQ_CTL, 8'h00);
        repeat (4)
        begin
            v = 8'($urandom) & 8'h3F;
            i_host.wr(rcw_pkg::OFF_TRIM, v);
            rd(rcw_pkg::OFF_TRIM); chk(q, v, "trim rw");
        end
        i_host.wr(rcw_pkg::OFF_FLAGS, 8'h04);
        rd(rcw_pkg::OFF_FLAGS); chk(q & 8'h04, 8'h00, "ungated");
        i_host.gate_wr(rcw_pkg::OFF_FLAGS, 8'h06, 8'h04);
        rd(rcw_pkg::OFF_FLAGS); chk(q & 8'h07, 8'h04, "cal set");
        count_tg(512); chk_tg(exp_tg(2'b01, 512), "cal test");
        i_host.gate_wr(rcw_pkg::OFF_FLAGS, 8'h02, 8'h00);
        for (int c = 0; c < 4; c++)
        begin
            i_host.wr(rcw_pkg::OFF_IRQ_CTL, 8'h10 | 8'(c));
            wait_cyc(4);
            count_tg(512); chk_tg(exp_tg(2'(c), 512), "wave");
        end
        @(negedge sys_clk);
        vcc_low = 1'b1;
        wait_cyc(3);
        chk({7'h0, int_oe_n_q}, 8'h01, "wave on backup");
        i_host.wr(rcw_pkg::OFF_TRIM, 8'h15);
        backup_low_level = 1'b1;
        wait_cyc(5);
        backup_low_level = 1'b0;
        vcc_low = 1'b0;
        wait_cyc(3);
        rd(rcw_pkg::OFF_TRIM); chk(q, v, "backup write");
        rd(rcw_pkg::OFF_FLAGS); chk(q & 8'h08, 8'h08, "backup fail");
        rd(rcw_pkg::OFF_FLAGS); chk(q & 8'h08, 8'h00, "bpf clear");
        i_host.wr(rcw_pkg::OFF_IRQ_CTL, 8'h80);
        i_host.wr(rcw_pkg::OFF_DOG, 8'h81);
        t = 0;
        while (int_oe_n_q !== 1'b0 && t < 2300)
        begin
            @(negedge sys_clk);
            t++;
        end
        chk({6'h0, int_oe_n_q, int_out_q}, 8'h01, "dog pin");
        rd(rcw_pkg::OFF_FLAGS); chk(q & 8'h80, 8'h80, "dog flag");
        wait_cyc(1);
        chk({7'h0, int_oe_n_q}, 8'h01, "dog pin clear");
        i_host.wr(rcw_pkg::OFF_DOG, 8'hC5);
        rd(rcw_pkg::OFF_DOG); chk(q & 8'hBF, 8'h01, "locked");
        i_host.wr(rcw_pkg::OFF_DOG, 8'h82);
        rd(rcw_pkg::OFF_FLAGS);
        repeat (4)
        begin
            wait_cyc(1500);
            i_host.wr(rcw_pkg::OFF_DOG, 8'h82);
        end
        rd(rcw_pkg::OFF_FLAGS); chk(q & 8'h80, 8'h00, "kicked");
        wait_cyc(4300);
        rd(rcw_pkg::OFF_FLAGS); chk(q & 8'h80, 8'h80, "expired");
        i_host.wr(rcw_pkg::OFF_DOG, 8'h80);
        rd(rcw_pkg::OFF_FLAGS);
        wait_cyc(4300);
        rd(rcw_pkg::OFF_FLAGS); chk(q & 8'h80, 8'h00, "disabled");
        wrap_up();
    end
endmodule : rcw_rtc_aux_tb_top
